// ### logic/move_exec_map.svh
// Constants for the data-move instruction executor: field widths, pointer update mode codes and reset values
`ifndef MOVE_EXEC_MAP_SVH
`define MOVE_EXEC_MAP_SVH

// ****************************************************************
// Field widths
// ****************************************************************
`define ADDR_W 16
`define BANK_W 6
`define PAGE_W 7
`define FILE_ADDR_W 7
`define OFFS_W 6

// ****************************************************************
// Pointer update mode codes
// ****************************************************************
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define PTR_RESET 16'h0000
`define ACC_RESET 8'h00
`define BANK_RESET 6'h00
`define PAGE_RESET 7'h00

`endif

// ### logic/move_exec_pkg.sv
// Types shared by the data-move instruction executor
package move_exec_pkg;

    typedef enum logic [5:0] {
        OP_NONE = 6'h01,
        OP_INDIRECT_MODE = 6'h02,
        OP_INDIRECT_OFFSET = 6'h04,
        OP_LOAD_BANK = 6'h08,
        OP_LOAD_PAGE = 6'h10,
        OP_LOAD_ACC = 6'h20
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_STORE = 3'h4
    } state_t;

endpackage

// ### logic/move_instruction_exec.sv
// Executor for indirect load, literal loads and accumulator store instructions
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "move_exec_map.svh"

module move_instruction_exec (
    input wire logic clk_sys, // 25 MHz instruction clock
    input wire logic reset, // Asynchronous, active high
    input wire logic start, // One-cycle request to execute one instruction
    input wire logic [2:0] op_sel, // 0 none,1 indirect mode,2 indirect offset,3 bank,4 page,5 acc lit,6 store
    input wire logic ptr_sel, // Chooses file pointer 0 or 1
    input wire logic [1:0] pointer_update_mode, // Pre/post inc/dec code
    input wire logic [5:0] offset_lit, // Signed relative offset, -32..31
    input wire logic [7:0] literal, // Immediate operand
    input wire logic [6:0] file_addr, // File register address field
    input wire logic ptr_load, // Writes ptr_load_val into selected pointer
    input wire logic [15:0] ptr_load_val, // Value for a direct pointer write
    input wire logic [7:0] mem_rdata, // Data sampled at the end of the cycle in which mem_rd is high
    output logic busy, // High in the read cycle of an indirect instruction only
    output logic done, // One-cycle pulse when an instruction completes
    output logic mem_rd, // One-cycle data memory read strobe
    output logic mem_wr, // One-cycle data memory write strobe
    output logic [15:0] mem_addr, // Data memory address
    output logic [7:0] mem_wdata, // Data memory write data
    output logic [7:0] acc, // Working accumulator
    output logic zero_flag, // Zero status flag
    output logic [5:0] bank_select_reg, // Bank select register
    output logic [6:0] pc_high_latch, // Program counter high latch
    output logic [15:0] file_pointer_0, // File pointer 0
    output logic [15:0] file_pointer_1 // File pointer 1
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic dec);
        // Plain 16-bit add keeps wrap-around free of any error path
        step_ptr = dec ? p - 16'h0001 : p + 16'h0001;
    endfunction

    function automatic logic [15:0] sel_ptr(input logic s, input logic [15:0] p0, input logic [15:0] p1);
        sel_ptr = s ? p1 : p0;
    endfunction

    move_exec_pkg::state_t state_reg;
    logic [15:0] cur_ptr;
    logic [15:0] offs_ext;

    assign cur_ptr = sel_ptr(ptr_sel, file_pointer_0, file_pointer_1);
    assign offs_ext = {{10{offset_lit[5]}}, offset_lit};

    // ****************************************************************
    // Request decode
    // ****************************************************************
    // A request is taken only while idle; in the read cycle it is dropped silently
    function automatic logic taken_as(input logic req, input logic idle, input logic [2:0] code,
            input logic [2:0] want);
        taken_as = req && idle && (code == want);
    endfunction

    logic in_idle;
    logic in_read;
    logic take_ind_mode;
    logic take_ind_offs;
    logic take_bank;
    logic take_page;
    logic take_acc;
    logic take_store;

    assign in_idle = (state_reg == move_exec_pkg::ST_IDLE);
    assign in_read = (state_reg == move_exec_pkg::ST_READ);
    assign take_ind_mode = taken_as(start, in_idle, op_sel, 3'h1);
    assign take_ind_offs = taken_as(start, in_idle, op_sel, 3'h2);
    assign take_bank = taken_as(start, in_idle, op_sel, 3'h3);
    assign take_page = taken_as(start, in_idle, op_sel, 3'h4);
    assign take_acc = taken_as(start, in_idle, op_sel, 3'h5);
    assign take_store = taken_as(start, in_idle, op_sel, 3'h6);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Only the indirect forms need a second cycle, for the read data to return
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= move_exec_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                move_exec_pkg::ST_IDLE: begin
                    if (take_ind_mode || take_ind_offs) begin
                        state_reg <= move_exec_pkg::ST_READ;
                    end
                end
                move_exec_pkg::ST_READ: begin
                    state_reg <= move_exec_pkg::ST_IDLE;
                end
                default: begin
                    // The store state is never entered; any stray code falls back to idle
                    state_reg <= move_exec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read handshake
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            mem_rd <= 1'b0;
        end else begin
            busy <= take_ind_mode || take_ind_offs;
            mem_rd <= take_ind_mode || take_ind_offs;
        end
    end

    // ****************************************************************
    // Write strobe and completion
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_wr <= 1'b0;
            done <= 1'b0;
        end else begin
            mem_wr <= take_store;
            // Literal and store forms finish in the cycle they are taken
            done <= take_bank || take_page || take_acc || take_store || in_read;
        end
    end

    // ****************************************************************
    // Memory address
    // ****************************************************************
    // Held between accesses so the last address stays visible
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_addr <= `PTR_RESET;
        end else if (take_ind_mode) begin
            if (pointer_update_mode[1]) begin
                mem_addr <= cur_ptr;
            end else begin
                mem_addr <= step_ptr(cur_ptr, pointer_update_mode[0]);
            end
        end else if (take_ind_offs) begin
            mem_addr <= cur_ptr + offs_ext;
        end else if (take_store) begin
            mem_addr <= {3'h0, bank_select_reg, file_addr};
        end
    end

    // ****************************************************************
    // Write data
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_wdata <= `ACC_RESET;
        end else if (take_store) begin
            mem_wdata <= acc;
        end
    end

    // ****************************************************************
    // Accumulator and zero flag
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc <= `ACC_RESET;
            zero_flag <= 1'b0;
        end else if (in_read) begin
            acc <= mem_rdata;
            zero_flag <= (mem_rdata == 8'h00);
        end else if (take_acc) begin
            acc <= literal;
        end
    end

    // ****************************************************************
    // Bank select and page latch (flags untouched)
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bank_select_reg <= `BANK_RESET;
            pc_high_latch <= `PAGE_RESET;
        end else begin
            if (take_bank) begin
                bank_select_reg <= literal[5:0];
            end
            if (take_page) begin
                pc_high_latch <= literal[6:0];
            end
        end
    end

    // ****************************************************************
    // File pointers
    // ****************************************************************
    // Offset loads never touch the pointer, so a direct write is held off then too
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            file_pointer_0 <= `PTR_RESET;
            file_pointer_1 <= `PTR_RESET;
        end else if (take_ind_mode) begin
            // Pre and post forms leave the pointer at the same stepped value
            if (ptr_sel) begin
                file_pointer_1 <= step_ptr(file_pointer_1, pointer_update_mode[0]);
            end else begin
                file_pointer_0 <= step_ptr(file_pointer_0, pointer_update_mode[0]);
            end
        end else if (ptr_load && in_idle && !take_ind_offs) begin
            // A direct write in the read cycle or with an indirect request is ignored to keep the pointer consistent
            if (ptr_sel) begin
                file_pointer_1 <= ptr_load_val;
            end else begin
                file_pointer_0 <= ptr_load_val;
            end
        end
    end

endmodule
`default_nettype wire

// ### dv/move_exec_assertions.sv
// Port checker for the data-move instruction executor
`timescale 1ns/1ps
`default_nettype none
module move_exec_assertions (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic start, // Request
    input wire logic [2:0] op_sel, // Opcode
    input wire logic ptr_sel, // Pointer pick
    input wire logic [1:0] pointer_update_mode, // Step mode
    input wire logic [5:0] offset_lit, // Offset
    input wire logic [7:0] literal, // Immediate
    input wire logic [6:0] file_addr, // File field
    input wire logic [7:0] mem_rdata, // Read data
    input wire logic busy, // Busy
    input wire logic done, // Done
    input wire logic mem_rd, // Read strobe
    input wire logic mem_wr, // Write strobe
    input wire logic [15:0] mem_addr, // Address
    input wire logic [7:0] mem_wdata, // Write data
    input wire logic [7:0] acc, // Accumulator
    input wire logic zero_flag, // Zero flag
    input wire logic [5:0] bank_select_reg, // Bank
    input wire logic [6:0] pc_high_latch, // Page
    input wire logic [15:0] file_pointer_0, // Pointer 0
    input wire logic [15:0] file_pointer_1 // Pointer 1
);
    // ****************************************************************
    // Taken requests; start while busy is refused, so busy gates it
    // ****************************************************************
    logic take;
    logic [15:0] offs_ext;
    assign take = start && !busy;
    assign offs_ext = {{10{offset_lit[5]}}, offset_lit};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_IND_DATA: assert property (mem_rd |=> done && !busy && acc == $past(mem_rdata)
        && zero_flag == (acc == 8'h00)) else $error("indirect load wrong");
    AST_READ_CYCLE: assert property (take && (op_sel == 3'h1 || op_sel == 3'h2)
        |=> busy && mem_rd ##1 !busy && !mem_rd) else $error("read cycle wrong");
    AST_PRE_INC: assert property (take && op_sel == 3'h1 && !ptr_sel
        && pointer_update_mode == 2'h0
        |=> mem_rd && file_pointer_0 == $past(file_pointer_0) + 16'h0001 && mem_addr == file_pointer_0)
        else $error("pre-increment wrong");
    AST_POST_DEC: assert property (take && op_sel == 3'h1 && ptr_sel
        && pointer_update_mode == 2'h3
        |=> file_pointer_1 == $past(file_pointer_1) - 16'h0001 && mem_addr == $past(file_pointer_1))
        else $error("post-decrement wrong");
    AST_OFFSET: assert property (take && op_sel == 3'h2 && !ptr_sel |=> $stable(file_pointer_0)
        && mem_addr == $past(file_pointer_0) + $past(offs_ext)) else $error("offset address wrong");
    AST_BANK: assert property (take && op_sel == 3'h3 |=> done && $stable(zero_flag)
        && {2'h0, bank_select_reg} == ($past(literal) & 8'h3F)) else $error("bank literal wrong");
    AST_PAGE: assert property (take && op_sel == 3'h4 |=> done && $stable(zero_flag)
        && {1'h0, pc_high_latch} == ($past(literal) & 8'h7F)) else $error("page literal wrong");
    AST_ACC: assert property (take && op_sel == 3'h5 |=> done && $stable(zero_flag)
        && acc == $past(literal)) else $error("acc literal wrong");
    AST_STORE: assert property (take && op_sel == 3'h6 |=> done && mem_wr
        && mem_wdata == $past(acc) && mem_addr == {3'h0, $past(bank_select_reg), $past(file_addr)})
        else $error("store wrong");
endmodule
bind move_instruction_exec move_exec_assertions u_chk (.clk_sys, .reset, .start, .op_sel, .ptr_sel,
    .pointer_update_mode, .offset_lit, .literal, .file_addr, .mem_rdata, .busy, .done, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .acc, .zero_flag, .bank_select_reg, .pc_high_latch, .file_pointer_0, .file_pointer_1);
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the data-move instruction executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, reset = 1'b1, start = 1'b0, ptr_sel = 1'b0, ptr_load = 1'b0;
    logic [2:0] op_sel = 3'h0;
    logic [1:0] pointer_update_mode = 2'h0;
    logic [5:0] offset_lit = 6'h00;
    logic [7:0] literal = 8'h00, mem_rdata = 8'h00, mem_wdata, acc;
    logic [6:0] file_addr = 7'h00, pc_high_latch;
    logic [15:0] ptr_load_val = 16'h0000, mem_addr, file_pointer_0, file_pointer_1;
    logic busy, done, mem_rd, mem_wr, zero_flag;
    logic [5:0] bank_select_reg;
    int n_errors = 0, checked = 0, cycles = 0;
    move_instruction_exec uut (.clk_sys, .reset, .start, .op_sel, .ptr_sel, .pointer_update_mode, .offset_lit,
        .literal, .file_addr, .ptr_load, .ptr_load_val, .mem_rdata, .busy, .done, .mem_rd, .mem_wr, .mem_addr,
        .mem_wdata, .acc, .zero_flag, .bank_select_reg, .pc_high_latch, .file_pointer_0, .file_pointer_1);
    always #20 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic set_ptr(input logic ps, input logic [15:0] v);
        @(posedge clk_sys);
        ptr_load <= 1'b1;
        ptr_sel <= ps;
        ptr_load_val <= v;
        @(posedge clk_sys);
        ptr_load <= 1'b0;
    endtask
    // ****************************************************************
    // One instruction; read data is offered in the same cycle as the read strobe
    // ****************************************************************
    task automatic issue(input logic [2:0] op, input logic ps, input logic [1:0] m, input logic [7:0] v, rd);
        @(posedge clk_sys);
        start <= 1'b1;
        op_sel <= op;
        ptr_sel <= ps;
        pointer_update_mode <= m;
        offset_lit <= v[5:0];
        literal <= v;
        file_addr <= v[6:0];
        @(posedge clk_sys);
        start <= 1'b0;
        mem_rdata <= rd;
        #1;
        if (op == 3'h1 || op == 3'h2) begin
            chk(mem_rd, 1'b1);
            chk(busy, 1'b1);
            @(posedge clk_sys);
            #1;
            chk(busy, 1'b0);
        end
        chk(done, 1'b1);
    endtask
    task automatic t_indirect;
        for (int m = 0; m < 4; m++) begin
            set_ptr(m[0], m[0] ? 16'h0000 : 16'hFFFF);
            issue(3'h1, m[0], m[1:0], 8'h00, {m[1:0], 6'h00});
            chk(acc, {8'h00, m[1:0], 6'h00});
            chk(zero_flag, m == 0);
            chk(mem_addr, m[1] ^ m[0] ? 16'hFFFF : 16'h0000);
            chk(m[0] ? file_pointer_1 : file_pointer_0, m[0] ? 16'hFFFF : 16'h0000);
        end
    endtask
    task automatic t_offset;
        for (int k = 0; k < 2; k++) begin
            set_ptr(1'b0, 16'h0010);
            issue(3'h2, 1'b0, 2'h0, k ? 8'h1F : 8'h20, 8'h77);
            chk(mem_addr, k ? 16'h002F : 16'hFFF0);
            chk(file_pointer_0, 16'h0010);
        end
    endtask
    task automatic t_literals;
        issue(3'h2, 1'b0, 2'h0, 8'h00, 8'h00);
        issue(3'h3, 1'b0, 2'h0, 8'hFF, 8'h00);
        chk(bank_select_reg, 6'h3F);
        issue(3'h4, 1'b0, 2'h0, 8'hFF, 8'h00);
        chk(pc_high_latch, 7'h7F);
        issue(3'h5, 1'b0, 2'h0, 8'h5A, 8'h00);
        chk(acc, 8'h5A);
        chk(zero_flag, 1'b1);
        issue(3'h6, 1'b0, 2'h0, 8'h55, 8'h00);
        chk(mem_wr, 1'b1);
        chk(mem_wdata, 8'h5A);
        chk(mem_addr, 16'h1FD5);
    endtask
    // A page load and a pointer write offered in the read cycle must both be dropped
    task automatic t_refused;
        set_ptr(1'b1, 16'h1234);
        @(posedge clk_sys);
        start <= 1'b1;
        op_sel <= 3'h2;
        ptr_sel <= 1'b1;
        offset_lit <= 6'h01;
        @(posedge clk_sys);
        op_sel <= 3'h4;
        literal <= 8'h00;
        ptr_load <= 1'b1;
        ptr_load_val <= 16'h0000;
        mem_rdata <= 8'h00;
        @(posedge clk_sys);
        start <= 1'b0;
        ptr_load <= 1'b0;
        #1;
        chk(done, 1'b1);
        chk(pc_high_latch, 7'h7F);
        chk(file_pointer_1, 16'h1234);
        chk(mem_addr, 16'h1235);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_indirect;
        t_offset;
        t_literals;
        t_refused;
        tally_and_finish;
    end
    // Generous ceiling; the whole sequence needs well under a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            tally_and_finish;
        end
    end
endmodule
`default_nettype wire
